// file: rtl/mac_framer_pkg.sv
// Purpose: Shared constants for the power-line MAC header framer.
// Assumes: Byte-wide streams, one clock, synchronous active-high reset.
// Notes: Frame control bit positions follow the 802.15.4 layout.
package mac_framer_pkg;
  localparam int DATA_W = 8;
  localparam int FIFO_DEPTH = 16;
  localparam int FIFO_AW = 4;
  // Frame control bit positions in the 16-bit field.
  localparam int FC_TYPE_LSB = 0;
  localparam int FC_SEC_BIT = 3;
  localparam int FC_PEND_BIT = 4;
  localparam int FC_ACKREQ_BIT = 5;
  localparam int FC_VER_LSB = 12;
  localparam logic [2:0] FTYPE_ACK = 3'h2;
  localparam logic [2:0] FTYPE_DATA = 3'h1;
  localparam logic [7:0] AUX_LEN_NONE = 8'h00;
  localparam logic [7:0] AUX_LEN_SIX = 8'h06;
  // Delimiter types sent to the PHY header logic.
  localparam logic [1:0] DELIM_NO_ACK = 2'h1;
  localparam logic [1:0] DELIM_ACK = 2'h0;
  localparam logic PRIO_NORMAL = 1'h0;
  localparam logic PRIO_HIGH = 1'h1;
  localparam int SEG_BYTES = 3;
endpackage

// file: rtl/mac_framer_fifo.sv
// Purpose: Synchronous FIFO in the framer's byte path.
// Assumes: Single clock, synchronous active-high reset.
// Notes: Full and empty are exact; clock enable freezes everything.
`timescale 1ns/1ps
module mac_framer_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16,
  parameter int AW = 4
) (
  input wire logic core_clk_in,
  input wire logic srst_in,
  input wire logic ce_in,
  input wire logic [WIDTH-1:0] wr_data_in,
  input wire logic wr_valid_in,
  output logic wr_ready_out,
  output logic [WIDTH-1:0] rd_data_out,
  output logic rd_valid_out,
  input wire logic rd_ready_in
);
  typedef struct packed {
    logic [AW:0] wptr;
    logic [AW:0] rptr;
    logic wr_rdy;
  } fifo_state_t;
  fifo_state_t st;
  fifo_state_t next_st;
  logic [WIDTH-1:0] mem [DEPTH];
  logic do_wr;
  logic do_rd;

  // Pointer arithmetic; the extra bit separates full from empty.
  always_comb begin
    next_st = st;
    do_wr = wr_valid_in && wr_ready_out;
    do_rd = rd_valid_out && rd_ready_in;
    if (do_wr) begin
      next_st.wptr = st.wptr + 1'b1;
    end
    if (do_rd) begin
      next_st.rptr = st.rptr + 1'b1;
    end
    // Ready is registered so the source sees a flop, not a comparator.
    next_st.wr_rdy = !((next_st.wptr[AW] != next_st.rptr[AW]) &&
                       (next_st.wptr[AW-1:0] == next_st.rptr[AW-1:0]));
  end

  // State and storage update.
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      st <= '0;
      st.wr_rdy <= 1'b1;
    end else if (ce_in) begin
      st <= next_st;
      if (do_wr) begin
        mem[st.wptr[AW-1:0]] <= wr_data_in;
      end
    end
  end

  assign wr_ready_out = st.wr_rdy;
  assign rd_valid_out = (st.wptr != st.rptr);
  assign rd_data_out = mem[st.rptr[AW-1:0]];
endmodule

// file: rtl/mac_header_framer.sv
// Purpose: Builds the MAC header of power-line frames and streams it out.
// Assumes: Upper MAC offers one frame descriptor and its payload bytes, in either order.
// Notes: Header bytes go first, payload follows through a 16-deep FIFO.
`timescale 1ns/1ps
module mac_header_framer (
  input wire logic core_clk_in,
  input wire logic srst_in,
  input wire logic ce_in,
  // Frame descriptor, taken when start_valid_in and start_ready_out.
  input wire logic start_valid_in,
  output logic start_ready_out,
  input wire logic traffic_priority_in,
  input wire logic ack_request_in,
  input wire logic [2:0] frame_type_in,
  input wire logic security_en_in,
  input wire logic pan_id_comp_in,
  input wire logic [1:0] dst_mode_in,
  input wire logic [1:0] src_mode_in,
  input wire logic [7:0] seq_num_in,
  input wire logic [7:0] aux_len_in,
  input wire logic [23:0] seg_ctrl_in,
  // Payload (addresses, aux header, payload, FCS) as a byte stream.
  input wire logic [7:0] pay_data_in,
  input wire logic pay_valid_in,
  input wire logic pay_last_in,
  output logic pay_ready_out,
  // Byte stream to the PHY.
  output logic [7:0] tx_data_out,
  output logic tx_valid_out,
  output logic tx_last_out,
  input wire logic tx_ready_in,
  // PHY frame control header indications.
  output logic [1:0] phy_delimiter_type_out,
  output logic frame_priority_param_out,
  output logic reject_out
);
  typedef enum logic [3:0] {
    S_IDLE = 4'h1,
    S_HDR = 4'h2,
    S_PAY = 4'h4,
    S_DRAIN = 4'h8
  } fr_state_t;

  typedef struct packed {
    fr_state_t fsm;
    logic [47:0] hdr;
    logic [2:0] hcnt;
    logic last_seen;
    logic [7:0] tx_data;
    logic tx_valid;
    logic tx_last;
    logic [1:0] delim;
    logic prio;
    logic reject;
    logic start_ready;
  } fr_regs_t;

  fr_regs_t st;
  fr_regs_t next_st;
  logic [15:0] fc;
  logic bad_req;
  logic f_valid;
  logic f_ready;
  logic [8:0] f_data;
  logic f_wr_ready;
  logic take;
  logic out_free;
  // Index of the last header byte: FC low, FC high, sequence, segments.
  localparam logic [2:0] HDR_LAST = 3'(mac_framer_pkg::SEG_BYTES + 2);

  // FIFO holds payload bytes plus the last flag; its ready stalls the source.
  mac_framer_fifo #(
    .WIDTH(9),
    .DEPTH(mac_framer_pkg::FIFO_DEPTH),
    .AW(mac_framer_pkg::FIFO_AW)
  ) u_fifo (
    .core_clk_in(core_clk_in),
    .srst_in(srst_in),
    .ce_in(ce_in),
    .wr_data_in({pay_last_in, pay_data_in}),
    .wr_valid_in(pay_valid_in),
    .wr_ready_out(f_wr_ready),
    .rd_data_out(f_data),
    .rd_valid_out(f_valid),
    .rd_ready_in(f_ready)
  );
  assign pay_ready_out = f_wr_ready;

  // Frame control: pending and version forced to zero, type from request.
  always_comb begin
    fc = 16'h0000;
    fc[mac_framer_pkg::FC_TYPE_LSB +: 3] = frame_type_in;
    fc[mac_framer_pkg::FC_SEC_BIT] = security_en_in;
    fc[mac_framer_pkg::FC_PEND_BIT] = 1'b0;
    fc[mac_framer_pkg::FC_ACKREQ_BIT] = ack_request_in;
    fc[6] = pan_id_comp_in;
    fc[11:10] = dst_mode_in;
    fc[mac_framer_pkg::FC_VER_LSB +: 2] = 2'h0;
    fc[15:14] = src_mode_in;
  end

  // Requests with an ack type or an illegal aux length are refused.
  assign bad_req = (frame_type_in == mac_framer_pkg::FTYPE_ACK) ||
                   ((aux_len_in != mac_framer_pkg::AUX_LEN_NONE) &&
                    (aux_len_in != mac_framer_pkg::AUX_LEN_SIX)) ||
                   (security_en_in &&
                    (aux_len_in != mac_framer_pkg::AUX_LEN_SIX));

  assign take = start_valid_in && st.start_ready;
  assign out_free = !st.tx_valid || tx_ready_in;
  assign f_ready = (st.fsm == S_PAY) && out_free && !st.last_seen;

  // Main sequencer: header bytes, then payload until the last byte.
  always_comb begin
    next_st = st;
    next_st.reject = 1'b0;
    if (st.tx_valid && tx_ready_in) begin
      next_st.tx_valid = 1'b0;
      next_st.tx_last = 1'b0;
    end
    case (st.fsm)
      S_IDLE: begin
        if (take) begin
          next_st.start_ready = 1'b0;
          if (bad_req) begin
            next_st.reject = 1'b1;
            next_st.start_ready = 1'b1;
          end else begin
            // Header is FC, sequence, then three segment control bytes.
            next_st.hdr = {fc[7:0], fc[15:8], seq_num_in, seg_ctrl_in};
            next_st.hcnt = 3'h0;
            next_st.last_seen = 1'b0;
            next_st.delim = ack_request_in ? mac_framer_pkg::DELIM_ACK :
                            mac_framer_pkg::DELIM_NO_ACK;
            next_st.prio = traffic_priority_in;
            next_st.fsm = S_HDR;
          end
        end
      end
      S_HDR: begin
        if (out_free) begin
          next_st.tx_data = st.hdr[47:40];
          next_st.tx_valid = 1'b1;
          next_st.tx_last = 1'b0;
          next_st.hdr = {st.hdr[39:0], 8'h00};
          next_st.hcnt = st.hcnt + 3'h1;
          if (st.hcnt == HDR_LAST) begin
            next_st.fsm = S_PAY;
          end
        end
      end
      S_PAY: begin
        if (f_ready && f_valid) begin
          next_st.tx_data = f_data[7:0];
          next_st.tx_valid = 1'b1;
          next_st.tx_last = f_data[8];
          if (f_data[8]) begin
            next_st.last_seen = 1'b1;
            next_st.fsm = S_DRAIN;
          end
        end
      end
      S_DRAIN: begin
        if (!next_st.tx_valid) begin
          next_st.fsm = S_IDLE;
          next_st.start_ready = 1'b1;
        end
      end
      default: begin
        next_st.fsm = S_IDLE;
        next_st.start_ready = 1'b1;
      end
    endcase
  end

  // Register the whole state; clock enable freezes it.
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      st <= '0;
      st.fsm <= S_IDLE;
      st.delim <= mac_framer_pkg::DELIM_NO_ACK;
      st.start_ready <= 1'b1;
    end else if (ce_in) begin
      st <= next_st;
    end
  end

  assign start_ready_out = st.start_ready;
  assign tx_data_out = st.tx_data;
  assign tx_valid_out = st.tx_valid;
  assign tx_last_out = st.tx_last;
  assign phy_delimiter_type_out = st.delim;
  assign frame_priority_param_out = st.prio;
  assign reject_out = st.reject;

  // The first header byte is frame control low: pending bit zero.
  property p_pend_zero;
    @(posedge core_clk_in) disable iff (srst_in)
    (st.fsm == S_HDR && st.hcnt == 3'h0 && ce_in && out_free) |=>
      !tx_data_out[mac_framer_pkg::FC_PEND_BIT];
  endproperty
  a_pend_zero: assert property (p_pend_zero)
    else $error("Frame pending bit not zero.");

  // Ack request bit sent matches the latched delimiter type.
  property p_ack_delim;
    @(posedge core_clk_in) disable iff (srst_in)
    (st.fsm == S_HDR && st.hcnt == 3'h0 && ce_in && out_free) |=>
      (tx_data_out[mac_framer_pkg::FC_ACKREQ_BIT] ==
       (phy_delimiter_type_out == mac_framer_pkg::DELIM_ACK));
  endproperty
  a_ack_delim: assert property (p_ack_delim)
    else $error("Ack request and delimiter type disagree.");

  // Frame version bits are zero in the second header byte.
  property p_ver_zero;
    @(posedge core_clk_in) disable iff (srst_in)
    (st.fsm == S_HDR && st.hcnt == 3'h1 && ce_in && out_free) |=>
      (tx_data_out[5:4] == 2'h0);
  endproperty
  a_ver_zero: assert property (p_ver_zero)
    else $error("Frame version bits not zero.");

  // An ack frame type request is refused the next cycle.
  property p_no_ack_type;
    @(posedge core_clk_in) disable iff (srst_in)
    (take && ce_in && frame_type_in == mac_framer_pkg::FTYPE_ACK) |=>
      (reject_out && st.fsm == S_IDLE);
  endproperty
  a_no_ack_type: assert property (p_no_ack_type)
    else $error("Ack frame type accepted.");

  // Bad aux length is refused.
  property p_aux_len;
    @(posedge core_clk_in) disable iff (srst_in)
    (take && ce_in && aux_len_in != mac_framer_pkg::AUX_LEN_NONE &&
     aux_len_in != mac_framer_pkg::AUX_LEN_SIX) |=> reject_out;
  endproperty
  a_aux_len: assert property (p_aux_len)
    else $error("Illegal auxiliary header length accepted.");

  // Delimiter follows the ack request of an accepted frame.
  property p_delim_map;
    @(posedge core_clk_in) disable iff (srst_in)
    (take && ce_in && !bad_req) |=>
      (phy_delimiter_type_out == (ack_request_in ?
       mac_framer_pkg::DELIM_ACK : mac_framer_pkg::DELIM_NO_ACK));
  endproperty
  a_delim_map: assert property (p_delim_map)
    else $error("Delimiter type mapping wrong.");

  // Priority is latched from the request.
  property p_prio;
    @(posedge core_clk_in) disable iff (srst_in)
    (take && ce_in && !bad_req) |=>
      (frame_priority_param_out == $past(traffic_priority_in));
  endproperty
  a_prio: assert property (p_prio)
    else $error("Priority not latched.");

  // Six header bytes precede payload, all three segment bytes included.
  property p_hdr_len;
    @(posedge core_clk_in) disable iff (srst_in)
    (st.fsm == S_HDR && ce_in && out_free) |=>
      (st.fsm == ((st.hcnt == HDR_LAST + 3'h1) ? S_PAY : S_HDR));
  endproperty
  a_hdr_len: assert property (p_hdr_len)
    else $error("Header sequencing wrong.");

  // Clock enable low holds every state bit of the sequencer.
  property p_freeze;
    @(posedge core_clk_in) disable iff (srst_in)
    !ce_in |=> $stable(st);
  endproperty
  a_freeze: assert property (p_freeze)
    else $error("State moved while clock enable was low.");

  // Sequence number and all three segment bytes are latched for sending.
  property p_seg_latch;
    @(posedge core_clk_in) disable iff (srst_in)
    (take && ce_in && !bad_req) |=>
      (st.hdr[23:0] == $past(seg_ctrl_in) &&
       st.hdr[31:24] == $past(seq_num_in));
  endproperty
  a_seg_latch: assert property (p_seg_latch)
    else $error("Segment control bytes not latched.");

  // The frame type sent in the first header byte is never the ack code.
  property p_no_ack_out;
    @(posedge core_clk_in) disable iff (srst_in)
    (st.fsm == S_HDR && st.hcnt == 3'h1 && tx_valid_out) |->
      (tx_data_out[mac_framer_pkg::FC_TYPE_LSB +: 3] !=
       mac_framer_pkg::FTYPE_ACK);
  endproperty
  a_no_ack_out: assert property (p_no_ack_out)
    else $error("Ack frame type code sent.");

  // No descriptor is taken while a frame is in flight.
  property p_busy;
    @(posedge core_clk_in) disable iff (srst_in)
    (st.fsm != S_IDLE) |-> !start_ready_out;
  endproperty
  a_busy: assert property (p_busy)
    else $error("Descriptor ready while a frame is in flight.");

  // Main scenarios: whole frame, refusal, full FIFO, stall, header end.
  c_frame: cover property (@(posedge core_clk_in) tx_valid_out && tx_last_out);
  c_reject: cover property (@(posedge core_clk_in) reject_out);
  c_full: cover property (@(posedge core_clk_in) !f_wr_ready);
  c_stall: cover property (@(posedge core_clk_in)
    tx_valid_out && !tx_ready_in);
  c_hdr_end: cover property (@(posedge core_clk_in)
    st.fsm == S_HDR && st.hcnt == HDR_LAST && out_free);
endmodule

// file: testbench/phy_fch_sink.sv
// Purpose: Behavioural PHY frame control header side of the tx stream.
// Assumes: A byte is taken on a rising edge where valid and ready are high.
// Notes: Slow mode offers ready every other cycle, so the framer must hold.
`timescale 1ns/1ps
module phy_fch_sink (
  input wire logic core_clk_in,
  input wire logic srst_in,
  input wire logic slow_in,
  input wire logic [7:0] tx_data_in,
  input wire logic tx_valid_in,
  input wire logic tx_last_in,
  output logic tx_ready_out
);
  logic [7:0] got[$];
  int last_idx;
  initial tx_ready_out = 1'b0;
  initial last_idx = -1;
  // Ready changes only just after an edge, and the byte is taken there too.
  always @(posedge core_clk_in) begin
    if (srst_in) begin
      tx_ready_out <= 1'b0;
    end else begin
      if (tx_valid_in && tx_ready_out) begin
        if (tx_last_in) begin
          last_idx = got.size();
        end
        got.push_back(tx_data_in);
      end
      tx_ready_out <= slow_in ? !tx_ready_out : 1'b1;
    end
  end
endmodule

// file: testbench/mac_header_framer_tb.sv
// Purpose: Self-checking bench for the power-line MAC header framer.
// Assumes: Payload is queued before the descriptor that frames it.
// Notes: Expected bytes are built here from the frame control layout.
`timescale 1ns/1ps
module mac_header_framer_tb;
  logic clk = 1'b0, rst = 1'b1, slow = 1'b0, ce = 1'b1;
  logic sv = 1'b0, prio = 1'b0, ackq = 1'b0, sec = 1'b0, panc = 1'b0;
  logic [2:0] ftype = 3'h1;
  logic [1:0] dmode = 2'h0, smode = 2'h0;
  logic [7:0] seq = 8'h00, aux = 8'h00, pd = 8'h00;
  logic [23:0] seg = 24'h000000;
  logic pv = 1'b0, pl = 1'b0;
  logic srdy, prdy, txv, txl, txr, rej, prio_o;
  logic [7:0] txd;
  logic [1:0] delim;
  int mismatches = 0, n_tests = 0;
  always #2 clk = !clk;
  mac_header_framer dut_u (.core_clk_in(clk), .srst_in(rst), .ce_in(ce),
    .start_valid_in(sv), .start_ready_out(srdy), .traffic_priority_in(prio),
    .ack_request_in(ackq), .frame_type_in(ftype), .security_en_in(sec),
    .pan_id_comp_in(panc), .dst_mode_in(dmode), .src_mode_in(smode),
    .seq_num_in(seq), .aux_len_in(aux), .seg_ctrl_in(seg),
    .pay_data_in(pd), .pay_valid_in(pv), .pay_last_in(pl),
    .pay_ready_out(prdy), .tx_data_out(txd), .tx_valid_out(txv),
    .tx_last_out(txl), .tx_ready_in(txr), .phy_delimiter_type_out(delim),
    .frame_priority_param_out(prio_o), .reject_out(rej));
  phy_fch_sink sink_u (.core_clk_in(clk), .srst_in(rst), .slow_in(slow),
    .tx_data_in(txd), .tx_valid_in(txv), .tx_last_in(txl),
    .tx_ready_out(txr));
  // One comparison; an unknown bit matches only the same unknown bit.
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask
  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // Waits at falling edges for a ready, then lets the taking edge pass.
  // Which ready: 0 is the descriptor side, 1 the payload side.
  task automatic take(input int which);
    int k;
    k = 0;
    @(negedge clk);
    while ((which == 1 ? prdy : srdy) !== 1'b1 && k < 200) begin
      @(negedge clk);
      k++;
    end
    if (k == 200) begin
      mismatches++;
      complete_run();
    end
    @(posedge clk);
  endtask
  // Offers one descriptor; its fields stay still until it is taken.
  task automatic desc(input logic p, a, input logic [2:0] t, input logic s,
                      input logic [7:0] al);
    sv <= 1'b1;
    prio <= p;
    ackq <= a;
    ftype <= t;
    sec <= s;
    aux <= al;
    take(0);
    sv <= 1'b0;
  endtask
  // Queues n bytes, builds the descriptor, then compares the whole frame.
  task automatic frame(input logic p, a, input logic [2:0] t, input logic s,
                       input logic [7:0] al, input int n);
    logic [15:0] fc;
    logic [7:0] exp[$];
    int k;
    sink_u.got.delete();
    // Let the caller's field updates settle before they are read here.
    @(posedge clk);
    for (k = 0; k < n; k++) begin
      pd <= seq + k[7:0];
      pl <= (k == n - 1);
      pv <= 1'b1;
      take(1);
    end
    pv <= 1'b0;
    @(negedge clk);
    if (n == mac_framer_pkg::FIFO_DEPTH) check(prdy, 1'b0);
    fc = {smode, 2'h0, dmode, 3'h0, panc, a, 1'b0, s, t};
    exp = {fc[7:0], fc[15:8], seq, seg[23:16], seg[15:8], seg[7:0]};
    for (k = 0; k < n; k++) exp.push_back(seq + k[7:0]);
    @(posedge clk);
    desc(p, a, t, s, al);
    k = 0;
    while (sink_u.got.size() < exp.size() && k < 400) begin
      @(negedge clk);
      k++;
    end
    check(sink_u.got.size(), exp.size());
    for (k = 0; k < exp.size() && k < sink_u.got.size(); k++) begin
      check(sink_u.got[k], exp[k]);
    end
    check(sink_u.last_idx, exp.size() - 1);
    check(delim, a ? mac_framer_pkg::DELIM_ACK
                   : mac_framer_pkg::DELIM_NO_ACK);
    check(prio_o, p);
    take(0);
    check(prdy, 1'b1);
    $display("Frame test done, %0d bytes", exp.size());
  endtask
  // A refused descriptor pulses reject for one cycle and sends nothing.
  task automatic refuse(input logic [2:0] t, input logic s,
                        input logic [7:0] al);
    desc(1'b0, 1'b0, t, s, al);
    @(negedge clk);
    check({rej, srdy, txv}, 3'h6);
    @(negedge clk);
    check(rej, 1'b0);
    @(posedge clk);
    $display("Refusal test done, type %0d aux %0d", t, al);
  endtask
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    check({srdy, txv, delim, prio_o, rej, prdy}, 7'h49);
    $display("Reset test done");
    @(posedge clk);
    // Clock enable low: an offered bad descriptor must not be taken.
    ce <= 1'b0;
    sv <= 1'b1;
    ftype <= mac_framer_pkg::FTYPE_ACK;
    repeat (3) begin
      @(negedge clk);
      check({rej, srdy, txv}, 3'h2);
    end
    @(posedge clk);
    sv <= 1'b0;
    ce <= 1'b1;
    $display("Freeze test done");
    // Full FIFO, stalled PHY, high priority, ack and six-byte aux header.
    slow <= 1'b1;
    panc <= 1'b1;
    dmode <= 2'h2;
    smode <= 2'h3;
    seq <= 8'h5A;
    seg <= 24'hA1B2C3;
    frame(mac_framer_pkg::PRIO_HIGH, 1'b1, mac_framer_pkg::FTYPE_DATA,
          1'b1, mac_framer_pkg::AUX_LEN_SIX, 16);
    // Prompt PHY, normal priority, command frame, no ack, no aux header.
    slow <= 1'b0;
    panc <= 1'b0;
    dmode <= 2'h3;
    smode <= 2'h2;
    seq <= 8'hF0;
    seg <= 24'h3C5A96;
    frame(mac_framer_pkg::PRIO_NORMAL, 1'b0, 3'h3, 1'b0,
          mac_framer_pkg::AUX_LEN_NONE, 3);
    refuse(mac_framer_pkg::FTYPE_ACK, 1'b0, 8'h00);
    refuse(3'h1, 1'b0, 8'h04);
    refuse(3'h1, 1'b1, 8'h00);
    // Back-to-back after refusals: a beacon with a one-byte payload.
    frame(mac_framer_pkg::PRIO_HIGH, 1'b0, 3'h0, 1'b0, 8'h00, 1);
    complete_run();
  end
endmodule
